// ==== rtl/bim_pkg.sv ====
// Purpose: shared constants and types for the banked i/o register map
// Assumes: 8-bit registers, one per aligned 32-bit axi word
// Notes:   byte address is four times the register offset

package bim_pkg;

    ////////////////////////////////////////////////////////////////////////
    // address space
    localparam int SPACE_BYTES = 512;           // both banks together
    localparam int REG_AW      = 9;             // bank bit plus offset
    localparam int OFF_W       = 8;             // offset width
    localparam int AXI_AW      = 10;            // byte address width
    localparam int DATA_W      = 8;             // register width

    ////////////////////////////////////////////////////////////////////////
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // bank 0 register offsets
    localparam logic [7:0] OFF_PORT0_DATA = 8'h00, OFF_PORT0_IRQ_EN = 8'h01;
    localparam logic [7:0] OFF_PORT0_GSEL = 8'h02, OFF_PORT0_DRIVE2 = 8'h03;
    localparam logic [7:0] OFF_PORT1_DATA = 8'h04, OFF_PORT1_IRQ_EN = 8'h05;
    localparam logic [7:0] OFF_PORT1_GSEL = 8'h06, OFF_PORT1_DRIVE2 = 8'h07;
    localparam logic [7:0] OFF_PORT2_DATA = 8'h08, OFF_PORT2_IRQ_EN = 8'h09;
    localparam logic [7:0] OFF_PORT2_GSEL = 8'h0a, OFF_PORT2_DRIVE2 = 8'h0b;
    localparam logic [7:0] OFF_PORT3_DATA = 8'h0c, OFF_PORT3_IRQ_EN = 8'h0d;
    localparam logic [7:0] OFF_PORT3_GSEL = 8'h0e, OFF_PORT3_DRIVE2 = 8'h0f;
    localparam logic [7:0] OFF_DIG0_DATA0 = 8'h20, OFF_DIG0_DATA1   = 8'h21;
    localparam logic [7:0] OFF_DIG0_DATA2 = 8'h22, OFF_DIG0_CTRL0   = 8'h23;
    localparam logic [7:0] OFF_DIG1_DATA0 = 8'h24, OFF_DIG1_DATA1   = 8'h25;
    localparam logic [7:0] OFF_DIG1_DATA2 = 8'h26, OFF_DIG1_CTRL0   = 8'h27;
    localparam logic [7:0] OFF_COM2_DATA0 = 8'h28, OFF_COM2_DATA1   = 8'h29;
    localparam logic [7:0] OFF_PULSE_CTRL = 8'h62, OFF_CMP_CTRL0    = 8'h64;
    localparam logic [7:0] OFF_CONV0_CTRL = 8'h68, OFF_CONV1_CTRL   = 8'h69;
    localparam logic [7:0] OFF_CUR_PAGE   = 8'hd0, OFF_STK_PAGE     = 8'hd1;
    localparam logic [7:0] OFF_IDX_PAGE   = 8'hd3, OFF_MVR_PAGE     = 8'hd4;
    localparam logic [7:0] OFF_MVW_PAGE   = 8'hd5, OFF_TW_CONFIG    = 8'hd6;
    localparam logic [7:0] OFF_TW_STATUS  = 8'hd7, OFF_TW_MSTATUS   = 8'hd9;
    localparam logic [7:0] OFF_IRQ_CLR0   = 8'hda, OFF_IRQ_CLR1     = 8'hdb;
    localparam logic [7:0] OFF_IRQ_CLR3   = 8'hdd, OFF_IRQ_MASK3    = 8'hde;
    localparam logic [7:0] OFF_IRQ_MASK0  = 8'he0, OFF_IRQ_MASK1    = 8'he1;
    localparam logic [7:0] OFF_IRQ_VECTOR = 8'he2, OFF_WATCHDOG     = 8'he3;
    localparam logic [7:0] OFF_DEC_CTRL0  = 8'he6, OFF_DEC_CTRL1    = 8'he7;
    localparam logic [7:0] OFF_FLAGS      = 8'hf7;  // seen in both banks

    ////////////////////////////////////////////////////////////////////////
    // fields, reset values and per-bit write masks
    localparam int         FLAG_BANK_BIT = 4;       // bank select in flags
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] VECTOR_RESET  = 8'h00;
    localparam logic [7:0] STORE_RESET   = 8'h00;
    localparam logic [7:0] WMASK_NONE    = 8'h00;   // every bit read-only
    localparam logic [7:0] WMASK_ALL     = 8'hff;
    localparam logic [7:0] WMASK_CTRL    = 8'h01;   // enable bit only
    localparam logic [7:0] WMASK_TW      = 8'h0f;   // low nibble writable
    localparam logic [7:0] WMASK_CONV    = 8'hfe;   // top seven writable

    // access class of one register address
    typedef enum logic [2:0] {
        ACC_NONE = 3'b000,  // reserved location
        ACC_RW   = 3'b001,  // plain storage
        ACC_WO   = 3'b010,  // write only, reads zero
        ACC_BITS = 3'b011,  // per-bit access
        ACC_RC   = 3'b100,  // read clears
        ACC_FLAG = 3'b101   // flag register
    } bim_acc_t;

    // nine-bit register address from bank bit and offset
    function automatic logic [REG_AW-1:0] reg_addr(input logic       bank,
                                                   input logic [7:0] off);
        reg_addr = {bank, off};
    endfunction

endpackage

// ==== rtl/bim_store.sv ====
// Purpose: byte storage behind the plain registers of both banks
// Assumes: one write and one read port, read data registered
// Notes:   cleared by reset so reads are always defined

`timescale 1ns/1ps
`default_nettype none

module bim_store
    import bim_pkg::*;
#(
    parameter int DEPTH = SPACE_BYTES,         // bytes held
    parameter int AW    = REG_AW               // address width
) (
    input  wire logic          aclk,           // clock
    input  wire logic          aresetn,        // sync reset, low
    input  wire logic          we,             // write strobe
    input  wire logic [AW-1:0] waddr,          // write address
    input  wire logic [7:0]    wdata,          // write byte
    input  wire logic [AW-1:0] raddr,          // read address
    output logic      [7:0]    rdata           // registered read byte
);

    logic [7:0] mem [DEPTH];                   // storage array

    ////////////////////////////////////////////////////////////////////////
    // write port, cleared on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= STORE_RESET;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= STORE_RESET;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

`default_nettype wire

// ==== rtl/bim_decode.sv ====
// Purpose: access class and write mask for one register address
// Assumes: flag register appears at the same offset in both banks
// Notes:   bank one map holds plain storage apart from the flag register

`timescale 1ns/1ps
`default_nettype none

module bim_decode
    import bim_pkg::*;
(
    input  wire logic [REG_AW-1:0] addr,       // bank bit and offset
    output bim_acc_t               acc,        // access class
    output logic      [7:0]        wmask       // writable bits
);

    logic [7:0] off;                           // offset part

    assign off = addr[OFF_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // classify the address
    always_comb begin
        acc   = ACC_NONE;
        wmask = WMASK_ALL;
        if (off == OFF_FLAGS) begin
            acc = ACC_FLAG;
        end else if (addr[REG_AW-1]) begin
            acc = ACC_RW;                       // bank one storage
        end else begin
            case (off)
                OFF_PORT0_DATA, OFF_PORT0_IRQ_EN, OFF_PORT0_GSEL, OFF_PORT0_DRIVE2,
                OFF_PORT1_DATA, OFF_PORT1_IRQ_EN, OFF_PORT1_GSEL, OFF_PORT1_DRIVE2,
                OFF_PORT2_DATA, OFF_PORT2_IRQ_EN, OFF_PORT2_GSEL, OFF_PORT2_DRIVE2,
                OFF_PORT3_DATA, OFF_PORT3_IRQ_EN, OFF_PORT3_GSEL, OFF_PORT3_DRIVE2,
                OFF_DIG0_DATA2, OFF_DIG1_DATA2, OFF_PULSE_CTRL, OFF_CUR_PAGE,
                OFF_STK_PAGE, OFF_IDX_PAGE, OFF_MVR_PAGE, OFF_MVW_PAGE,
                OFF_TW_CONFIG, OFF_IRQ_CLR0, OFF_IRQ_CLR1, OFF_IRQ_CLR3,
                OFF_IRQ_MASK3, OFF_IRQ_MASK0, OFF_IRQ_MASK1, OFF_DEC_CTRL0,
                OFF_DEC_CTRL1: acc = ACC_RW;
                OFF_DIG0_DATA1, OFF_DIG1_DATA1, OFF_COM2_DATA1,
                OFF_WATCHDOG: acc = ACC_WO;
                OFF_DIG0_DATA0, OFF_DIG1_DATA0, OFF_COM2_DATA0: begin
                    acc   = ACC_BITS;
                    wmask = WMASK_NONE;
                end
                OFF_DIG0_CTRL0, OFF_DIG1_CTRL0, OFF_CMP_CTRL0: begin
                    acc   = ACC_BITS;
                    wmask = WMASK_CTRL;
                end
                OFF_TW_STATUS, OFF_TW_MSTATUS: begin
                    acc   = ACC_BITS;
                    wmask = WMASK_TW;
                end
                OFF_CONV0_CTRL, OFF_CONV1_CTRL: begin
                    acc   = ACC_BITS;
                    wmask = WMASK_CONV;
                end
                OFF_IRQ_VECTOR: acc = ACC_RC;
                default: acc = ACC_NONE;        // reserved
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== rtl/bim_regmap.sv ====
// Purpose: axi4-lite slave for the banked 8-bit i/o register space
// Assumes: one write and one read under way at a time
// Notes:   bank chosen by the flag register, not by the bus address

`timescale 1ns/1ps
`default_nettype none

module bim_regmap
    import bim_pkg::*;
(
    input  wire logic              aclk,            // clock, 10 mhz
    input  wire logic              aresetn,         // sync reset, low
    input  wire logic [AXI_AW-1:0] awaddr,          // write address
    input  wire logic [2:0]        awprot,          // unused protection
    input  wire logic              awvalid,         // write address valid
    output logic                   awready,         // write address ready
    input  wire logic [31:0]       wdata,           // write data
    input  wire logic [3:0]        wstrb,           // byte strobes
    input  wire logic              wvalid,          // write data valid
    output logic                   wready,          // write data ready
    output logic      [1:0]        bresp,           // write response
    output logic                   bvalid,          // write response valid
    input  wire logic              bready,          // write response ready
    input  wire logic [AXI_AW-1:0] araddr,          // read address
    input  wire logic [2:0]        arprot,          // unused protection
    input  wire logic              arvalid,         // read address valid
    output logic                   arready,         // read address ready
    output logic      [31:0]       rdata,           // read data
    output logic      [1:0]        rresp,           // read response
    output logic                   rvalid,          // read data valid
    input  wire logic              rready,          // read data ready
    input  wire logic [7:0]        periph_status,   // read-only bit values
    input  wire logic              vector_load,     // new vector pulse
    input  wire logic [7:0]        vector_in,       // vector to load
    output logic                   bank_select_bit, // current bank
    output logic                   watchdog_restart // restart pulse
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,                        // waiting for address
        RD_MEM  = 2'b01,                        // storage read issued
        RD_FORM = 2'b10,                        // forming the answer
        RD_RESP = 2'b11                         // answer on the bus
    } bim_rd_t;

    bim_rd_t           rd_state;                // read sequencer
    logic              aw_held;                 // address captured
    logic [7:0]        aw_off;                  // captured write offset
    logic              w_held;                  // data captured
    logic [7:0]        w_byte;                  // captured low byte
    logic              w_en;                    // low lane strobed
    logic              do_write;                // write happens now
    logic [REG_AW-1:0] wr_addr;                 // nine-bit write address
    bim_acc_t          wr_acc;                  // write access class
    logic [7:0]        wr_mask;                 // write bit mask
    logic [7:0]        ar_off;                  // captured read offset
    logic              rd_bank;                 // bank at read time
    logic [REG_AW-1:0] rd_addr;                 // nine-bit read address
    bim_acc_t          rd_acc;                  // read access class
    logic [7:0]        rd_mask;                 // read bit mask
    logic [7:0]        store_q;                 // storage read byte
    logic [7:0]        flags;                   // flag register
    logic [7:0]        irq_vector_q;            // clear-on-read vector
    logic              store_we;                // storage write strobe
    logic [7:0]        store_wd;                // storage write byte
    logic [7:0]        next_rbyte;              // composed read byte
    logic [1:0]        next_rresp;              // composed read response

    assign bank_select_bit = flags[FLAG_BANK_BIT];

    ////////////////////////////////////////////////////////////////////////
    // address forming and decode
    assign wr_addr = reg_addr(bank_select_bit, aw_off);
    assign rd_addr = reg_addr(rd_bank, ar_off);

    bim_decode u_wr_dec (
        .addr  (wr_addr),
        .acc   (wr_acc),
        .wmask (wr_mask)
    );

    bim_decode u_rd_dec (
        .addr  (rd_addr),
        .acc   (rd_acc),
        .wmask (rd_mask)
    );

    ////////////////////////////////////////////////////////////////////////
    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_off  <= 8'h00;
            awready <= 1'b0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_off  <= awaddr[AXI_AW-1:2];
            awready <= 1'b0;                    // hold until written
        end else begin
            if (do_write) begin
                aw_held <= 1'b0;
            end
            if (!aw_held) begin
                awready <= 1'b1;
            end
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_en   <= 1'b0;
            wready <= 1'b0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];               // narrow data in low lane
            w_en   <= wstrb[0];
            wready <= 1'b0;
        end else begin
            if (do_write) begin
                w_held <= 1'b0;
            end
            if (!w_held) begin
                wready <= 1'b1;
            end
        end
    end

    // both halves present and no response pending
    assign do_write = aw_held && w_held && !bvalid;

    ////////////////////////////////////////////////////////////////////////
    // storage write: plain bytes, or only the writable bits
    always_comb begin
        store_we = 1'b0;
        store_wd = w_byte;
        if (do_write && w_en) begin
            case (wr_acc)
                ACC_RW, ACC_WO: store_we = 1'b1;
                ACC_BITS: begin
                    store_we = 1'b1;
                    store_wd = w_byte & wr_mask;
                end
                default: store_we = 1'b0;       // vector, flags, reserved
            endcase
        end
    end

    bim_store u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (store_we),
        .waddr   (wr_addr),
        .wdata   (store_wd),
        .raddr   (rd_addr),
        .rdata   (store_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // flag register, holds the bank select bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= FLAGS_RESET;
        end else if (do_write && w_en && wr_acc == ACC_FLAG) begin
            flags <= w_byte;
        end
    end

    // watchdog restart pulse on a write to its bank zero offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_restart <= 1'b0;
        end else begin
            watchdog_restart <= do_write && w_en && !bank_select_bit
                                && aw_off == OFF_WATCHDOG;
        end
    end

    // write response, error for reserved locations
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= (wr_acc == ACC_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            arready  <= 1'b0;
            ar_off   <= 8'h00;
            rd_bank  <= 1'b0;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    arready <= 1'b1;
                    if (arvalid && arready) begin
                        arready  <= 1'b0;
                        ar_off   <= araddr[AXI_AW-1:2];
                        rd_bank  <= bank_select_bit;
                        rd_state <= RD_MEM;
                    end
                end
                RD_MEM:  rd_state <= RD_FORM;   // storage byte arrives
                RD_FORM: rd_state <= RD_RESP;
                RD_RESP: begin
                    if (rready) begin
                        rd_state <= RD_IDLE;
                    end
                end
                default: rd_state <= RD_IDLE;
            endcase
        end
    end

    // compose the read byte by access class
    always_comb begin
        next_rbyte = 8'h00;
        next_rresp = RESP_OKAY;
        case (rd_acc)
            ACC_RW:   next_rbyte = store_q;
            ACC_WO:   next_rbyte = 8'h00;       // write only reads zero
            ACC_BITS: next_rbyte = (store_q & rd_mask)
                                   | (periph_status & ~rd_mask);
            ACC_RC:   next_rbyte = irq_vector_q;
            ACC_FLAG: next_rbyte = flags;
            default:  next_rresp = RESP_SLVERR;
        endcase
    end

    // read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (rd_state == RD_FORM) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, next_rbyte};
            rresp  <= next_rresp;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear-on-read vector; a load in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_vector_q <= VECTOR_RESET;
        end else if (vector_load) begin
            irq_vector_q <= vector_in;
        end else if (rd_state == RD_FORM && rd_acc == ACC_RC) begin
            irq_vector_q <= VECTOR_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    space_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_state == RD_MEM |-> 32'(rd_addr) < SPACE_BYTES)
        else $error("read address outside register space");

    bank_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rd_bank == $past(bank_select_bit))
        else $error("read bank not taken from flag bit");

    flag_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && w_en && wr_acc == ACC_FLAG
        |=> bank_select_bit == $past(w_byte[FLAG_BANK_BIT]))
        else $error("flag write did not set bank");

    bank_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        store_we |-> wr_addr[REG_AW-1] == bank_select_bit)
        else $error("write sent to wrong bank");

    reserved_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_state == RD_FORM && rd_acc == ACC_NONE
        |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("reserved read not refused");

    read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_state == RD_FORM && rd_acc == ACC_RC && !vector_load
        |=> irq_vector_q == VECTOR_RESET && rdata[7:0] == $past(irq_vector_q))
        else $error("vector not returned and cleared");

    bit_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_state == RD_FORM && rd_acc == ACC_BITS
        |=> (rdata[7:0] & ~$past(rd_mask)) == ($past(periph_status) & ~$past(rd_mask)))
        else $error("read-only bits not from status");

    addr_form_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready |-> ##1 rd_addr == {rd_bank, $past(araddr[AXI_AW-1:2])})
        else $error("read address not bank over offset");

    read_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready |-> !rvalid [*3] ##1 rvalid)
        else $error("read answer not three cycles later");

    bank1_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && bank_select_bit |=> !watchdog_restart)
        else $error("bank one write reached bank zero");

    ro_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
        store_we && wr_acc == ACC_BITS |-> (store_wd & ~wr_mask) == 8'h00)
        else $error("read-only bits stored");

    load_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        vector_load |=> irq_vector_q == $past(vector_in))
        else $error("vector load lost to clear");

    cover_bank1_c: cover property (@(posedge aclk) disable iff (!aresetn)
        store_we && bank_select_bit);
    cover_clear_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_state == RD_FORM && rd_acc == ACC_RC);
    cover_err_c: cover property (@(posedge aclk) disable iff (!aresetn)
        bvalid && bresp == RESP_SLVERR);
    cover_bits_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rd_state == RD_FORM && rd_acc == ACC_BITS);
    cover_rderr_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rvalid && rresp == RESP_SLVERR);

endmodule

`default_nettype wire

// ==== sim/bim_periph.sv ====
// Purpose: peripheral side model, status bits and vector loads
// Assumes: bench raises fire for one cycle to load a vector
// Notes:   status is a mixed pattern so stuck bits show
`timescale 1ns/1ps
`default_nettype none
module bim_periph #(
    parameter logic [7:0] STATUS = 8'h5a  // read-only bit values
) (
    input  wire logic       fire,          // load request
    input  wire logic [7:0] vec,           // vector value
    output logic      [7:0] periph_status, // status bits
    output logic            vector_load,   // load pulse
    output logic      [7:0] vector_in      // loaded vector
);
    assign periph_status = STATUS;
    assign vector_load   = fire;
    assign vector_in     = vec;
endmodule
`default_nettype wire

// ==== sim/test_bim_regmap.sv ====
// Purpose: self-checking bench for the banked register map
// Assumes: flag register at 0xf7, bank bit 4
// Notes:   xorshift values, seed 32'h5ae1
`timescale 1ns/1ps
`default_nettype none
module test_bim_regmap
    import bim_pkg::*;
;
    localparam logic [7:0] PS = 8'h5a; // peer status bits
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
    logic awready, wready, bvalid, arready, rvalid, bank_select_bit, watchdog_restart, vl;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [7:0]  ps, vi, vec, v, b0, a;
    logic [15:0] tab [4] = '{{OFF_DIG0_DATA0, WMASK_NONE}, {OFF_DIG0_CTRL0, WMASK_CTRL},
                             {OFF_TW_STATUS, WMASK_TW}, {OFF_CONV0_CTRL, WMASK_CONV}};
    int fail_count = 0, n_tests = 0, wd_n = 0;
    bim_regmap dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .periph_status(ps), .vector_load(vl),
        .vector_in(vi), .bank_select_bit(bank_select_bit), .watchdog_restart(watchdog_restart));
    bim_periph #(.STATUS(PS)) peer (.fire(fire), .vec(vec), .periph_status(ps),
        .vector_load(vl), .vector_in(vi));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) if (watchdog_restart === 1'b1) wd_n <= wd_n + 1;
    initial begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // write with address and data offered together
    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er);
        awaddr <= {ad, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e, input logic [1:0] er);
        araddr <= {ad, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk("rdata", {24'h0, e}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, fire} = '0;
        {awaddr, araddr, wdata, vec} = '0;
        wstrb = 4'h1;
        seed = 32'h5ae1;
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFF_FLAGS, FLAGS_RESET, RESP_OKAY);
        rd(OFF_IRQ_VECTOR, VECTOR_RESET, RESP_OKAY);
        repeat (20) begin
            a = xs() & 8'h0f;
            v = xs();
            wr(a, v, RESP_OKAY);
            rd(a, v, RESP_OKAY);
        end
        b0 = xs();
        wr(8'h10, b0, RESP_SLVERR);
        rd(8'h10, 8'h00, RESP_SLVERR);
        wr(OFF_PORT0_DATA, b0, RESP_OKAY);
        wstrb <= 4'h0;
        wr(OFF_PORT0_DATA, ~b0, RESP_OKAY);
        wstrb <= 4'h1;
        wr(OFF_FLAGS, 8'h10, RESP_OKAY);
        chk("bank", 32'h1, {31'h0, bank_select_bit});
        wr(OFF_PORT0_DATA, ~b0, RESP_OKAY);
        wr(8'h10, b0, RESP_OKAY);
        rd(OFF_PORT0_DATA, ~b0, RESP_OKAY);
        wr(OFF_FLAGS, 8'h00, RESP_OKAY);
        rd(OFF_PORT0_DATA, b0, RESP_OKAY);
        foreach (tab[i]) begin
            v = xs();
            wr(tab[i][15:8], v, RESP_OKAY);
            rd(tab[i][15:8], (v & tab[i][7:0]) | (PS & ~tab[i][7:0]), RESP_OKAY);
        end
        wr(OFF_DIG0_DATA1, v, RESP_OKAY);
        rd(OFF_DIG0_DATA1, 8'h00, RESP_OKAY);
        vec <= v | 8'h80;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        rd(OFF_IRQ_VECTOR, v | 8'h80, RESP_OKAY);
        rd(OFF_IRQ_VECTOR, 8'h00, RESP_OKAY);
        wr(OFF_WATCHDOG, v, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("wdog", 32'h1, wd_n);
        tally_and_finish();
    end
endmodule
`default_nettype wire
